// >>> rtl/hgd_top.v
// The register offsets and the APB interface to the registers were decided locally.
`include "hgd_consts.vh"

module hgd_top #(
   parameter RETRY_CYCLES = `HGD_RETRY_NS * `HGD_CLK_MHZ / 1000,
   parameter ADC_W = 12
) (
   input wire clock, // 100 MHz system clock
   input wire rstn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb write
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error on unmapped address
   output reg irq, // level interrupt
   input wire [1:0] bridgeWantHigh, // per half-bridge: high side wanted
   input wire [1:0] bridgeEnable, // per half-bridge: drive enabled
   input wire [1:0] highOffDet, // high gates seen off
   input wire [1:0] lowOffDet, // low gates seen off
   input wire [ADC_W-1:0] sensePositive, // sense node, mV
   input wire [ADC_W-1:0] senseNegative, // sense return, mV
   input wire [ADC_W-1:0] drainSupplySense, // drain supply, mV
   input wire [ADC_W-1:0] halfBridgeOutputOne, // output 1, mV
   input wire [ADC_W-1:0] halfBridgeOutputTwo, // output 2, mV
   input wire [ADC_W-1:0] lowSideSourceTwo, // low source 2, mV
   input wire [ADC_W-1:0] driveStrengthPinMv, // strength pin level, mV
   input wire [ADC_W-1:0] vdsPinMv, // threshold pin level, mV
   output reg [1:0] highSideGate, // high gates on
   output reg [1:0] lowSideGate, // low gates on
   output reg [3:0] gatePeakActive, // {lo2,hi2,lo1,hi1} peak phase
   output reg [3:0] gateHoldCurrent, // {lo2,hi2,lo1,hi1} hold phase
   output reg [1:0] strongGatePulldown, // low gate strong pulldown
   output reg [8:0] peakSourceHighMa, // high-side source, mA
   output reg [8:0] peakSourceLowMa, // low-side source, mA
   output reg [9:0] peakSinkHighMa, // high-side sink, mA
   output reg [9:0] peakSinkLowMa, // low-side sink, mA
   output reg [ADC_W-1:0] drainSourceThreshold, // active trip level, mV
   output reg ampOutputEnable, // amplifier output drives when high
   output reg overcurrentDetect, // overcurrent seen the cycle before
   output reg faultOutN, // open-drain fault level, always 0
   output reg faultOutOe // fault pin pulled low when high
);
   // cycle counts, least times rounded up
   localparam DRIVE_CYC = (`HGD_DRIVE_NS * `HGD_CLK_MHZ + 999) / 1000;
   localparam IN_DGL_CYC = (`HGD_IN_DEGLITCH_NS * `HGD_CLK_MHZ + 999) / 1000;
   localparam OCP_DGL_CYC = (`HGD_OCP_DEGLITCH_NS * `HGD_CLK_MHZ + 999) / 1000;
   localparam DEAD_CYC_0 = (`HGD_DEAD_NS_0 * `HGD_CLK_MHZ + 999) / 1000;
   localparam DEAD_CYC_1 = (`HGD_DEAD_NS_1 * `HGD_CLK_MHZ + 999) / 1000;
   localparam DEAD_CYC_2 = (`HGD_DEAD_NS_2 * `HGD_CLK_MHZ + 999) / 1000;
   localparam DEAD_CYC_3 = (`HGD_DEAD_NS_3 * `HGD_CLK_MHZ + 999) / 1000;
   localparam [ADC_W-1:0] SENSE_TRIP = `HGD_SENSE_OCP_MV;
   localparam RW = $clog2(RETRY_CYCLES + 1);
   localparam [RW-1:0] RETRY_LOAD = RETRY_CYCLES[RW-1:0];

   // a exceeds b by more than thr
   function overBy;
      input [ADC_W-1:0] a;
      input [ADC_W-1:0] b;
      input [ADC_W-1:0] thr;
      begin
         overBy = (a > b) && ((a - b) > thr);
      end
   endfunction

   // six-level pin decode, shared by strength and threshold pins
   function [2:0] levelDecode;
      input [ADC_W-1:0] mv;
      begin
         if (mv < `HGD_LVL_MV_0) levelDecode = 3'h0;
         else if (mv < `HGD_LVL_MV_1) levelDecode = 3'h1;
         else if (mv < `HGD_LVL_MV_2) levelDecode = 3'h2;
         else if (mv < `HGD_LVL_MV_3) levelDecode = 3'h3;
         else if (mv < `HGD_LVL_MV_4) levelDecode = 3'h4;
         else levelDecode = 3'h5;
      end
   endfunction

   // peak source current per setting, high or low side
   function [8:0] sourceMa;
      input [2:0] sel;
      input highSide;
      begin
         case (sel)
            3'h0: sourceMa = 9'h00a;
            3'h1: sourceMa = 9'h014;
            3'h2: sourceMa = highSide ? 9'h032 : 9'h02d;
            3'h3: sourceMa = highSide ? 9'h09b : 9'h082;
            3'h4: sourceMa = highSide ? 9'h0d2 : 9'h0b4;
            default: sourceMa = highSide ? 9'h104 : 9'h0e1;
         endcase
      end
   endfunction

   // control and status registers
   reg [9:0] ctrlReg; // configuration
   reg [1:0] statusReg; // sticky events
   reg [1:0] maskReg; // interrupt mask
   reg [2:0] driveSel; // latched strength setting
   reg faultActive; // bridge shut down, retry running
   reg [RW-1:0] retryCnt; // retry countdown
   reg senseOcp; // sense differential over limit

   wire serialCfg = ctrlReg[`HGD_CTRL_SERIAL];
   wire shEnable = ctrlReg[`HGD_CTRL_SHEN];
   wire [1:0] deadCode = ctrlReg[`HGD_CTRL_DEAD_HI:`HGD_CTRL_DEAD_LO];
   wire [2:0] drvCode = ctrlReg[`HGD_CTRL_DRV_HI:`HGD_CTRL_DRV_LO];
   wire [2:0] vdsCode = ctrlReg[`HGD_CTRL_VDS_HI:`HGD_CTRL_VDS_LO];

   // deglitched control inputs {enable, wantHigh}
   wire [3:0] ctrlClean;
   hgd_deglitch #(
      .WIDTH(4),
      .COUNT(IN_DGL_CYC)
   ) uCtrlDgl (
      .clock(clock),
      .rstn(rstn),
      .rawIn({bridgeEnable, bridgeWantHigh}),
      .cleanOut(ctrlClean)
   );

   // dead time: fixed in pin variant, programmable in serial variant
   reg [7:0] deadCycles;
   always @* begin
      case (serialCfg ? deadCode : 2'h1)
         2'h0: deadCycles = DEAD_CYC_0[7:0];
         2'h1: deadCycles = DEAD_CYC_1[7:0];
         2'h2: deadCycles = DEAD_CYC_2[7:0];
         default: deadCycles = DEAD_CYC_3[7:0];
      endcase
   end

   // two half-bridge sequencers
   wire [1:0] hbHigh;
   wire [1:0] hbLow;
   wire [1:0] hbPeak;
   wire [1:0] hbStrong;
   wire [1:0] hbBusy;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gHalf
         hgd_half_bridge #(
            .DRIVE_CYCLES(DRIVE_CYC)
         ) uHalf (
            .clock(clock),
            .rstn(rstn),
            .enable(ctrlClean[2 + g] & ~faultActive),
            .wantHigh(ctrlClean[g]),
            .highOffDet(highOffDet[g]),
            .lowOffDet(lowOffDet[g]),
            .deadCycles(deadCycles),
            .highGate(hbHigh[g]),
            .lowGate(hbLow[g]),
            .peakDrive(hbPeak[g]),
            .strongPull(hbStrong[g]),
            .busy(hbBusy[g])
         );
      end
   endgenerate

   // threshold select: pin level or register, codes 5 to 7 disable
   wire [2:0] vdsSel = serialCfg ? vdsCode : levelDecode(vdsPinMv);
   reg [ADC_W-1:0] vdsTrip;
   always @* begin
      case (vdsSel)
         3'h0: vdsTrip = `HGD_VDS_MV_0;
         3'h1: vdsTrip = `HGD_VDS_MV_1;
         3'h2: vdsTrip = `HGD_VDS_MV_2;
         3'h3: vdsTrip = `HGD_VDS_MV_3;
         3'h4: vdsTrip = `HGD_VDS_MV_4;
         default: vdsTrip = {ADC_W{1'b1}};
      endcase
   end
   wire vdsOn = (vdsSel < 3'h5);

   // raw drain-source compare on conducting FETs {lo2,hi2,lo1,hi1}
   wire [3:0] conducting = {hbLow[1], hbHigh[1], hbLow[0], hbHigh[0]} & ~{hbPeak[1], hbPeak[1], hbPeak[0], hbPeak[0]};
   wire [3:0] vdsRaw;
   assign vdsRaw[0] = conducting[0] & vdsOn & overBy(drainSupplySense, halfBridgeOutputOne, vdsTrip);
   assign vdsRaw[1] = conducting[1] & vdsOn & overBy(halfBridgeOutputOne, sensePositive, vdsTrip);
   assign vdsRaw[2] = conducting[2] & vdsOn & overBy(drainSupplySense, halfBridgeOutputTwo, vdsTrip);
   assign vdsRaw[3] = conducting[3] & vdsOn & overBy(halfBridgeOutputTwo, lowSideSourceTwo, vdsTrip);

   // overcurrent must persist for the deglitch time
   wire [3:0] vdsTripClean;
   hgd_deglitch #(
      .WIDTH(4),
      .COUNT(OCP_DGL_CYC)
   ) uVdsDgl (
      .clock(clock),
      .rstn(rstn),
      .rawIn(vdsRaw),
      .cleanOut(vdsTripClean)
   );
   wire vdsOcp = |vdsTripClean;
   wire anyOcp = vdsOcp | senseOcp;

   // apb decode
   wire setup = psel & ~penable;
   wire wrAccess = psel & penable & pwrite & pready;
   wire mapped = (paddr == `HGD_OFS_CTRL) | (paddr == `HGD_OFS_STATUS) |
                 (paddr == `HGD_OFS_MASK) | (paddr == `HGD_OFS_STATE);
   wire ctrlWr = wrAccess & ~pslverr & (paddr == `HGD_OFS_CTRL);
   wire statusWr = wrAccess & ~pslverr & (paddr == `HGD_OFS_STATUS);
   wire maskWr = wrAccess & ~pslverr & (paddr == `HGD_OFS_MASK);

   // events seen this cycle
   wire [1:0] events;
   assign events[`HGD_ST_VDS_OCP] = vdsOcp;
   assign events[`HGD_ST_SENSE_OCP] = senseOcp;

   // sticky status: a new event beats a clearing write
   wire [1:0] statusNext = (statusReg & ~(statusWr ? pwdata[1:0] : 2'h0)) | events;

   // read mux
   reg [31:0] readValue;
   always @* begin
      readValue = 32'h0000_0000;
      case (paddr)
         `HGD_OFS_CTRL: readValue = {22'h0, ctrlReg};
         `HGD_OFS_STATUS: readValue = {30'h0, statusReg};
         `HGD_OFS_MASK: readValue = {30'h0, maskReg};
         `HGD_OFS_STATE: readValue = {19'h0, vdsSel, driveSel, hbBusy, hbLow, hbHigh, faultActive};
         default: readValue = 32'h0000_0000;
      endcase
   end

   // apb slave: answers in the first access cycle
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup; // ready one cycle after setup
         pslverr <= setup & ~mapped; // unmapped answered with error
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : readValue;
         end
      end
   end

   // register writes and sticky status
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrlReg <= `HGD_CTRL_RESET;
         statusReg <= `HGD_STATUS_RESET;
         maskReg <= `HGD_MASK_RESET;
         irq <= 1'b0;
      end else begin
         if (ctrlWr) begin
            ctrlReg <= pwdata[9:0];
         end
         if (maskWr) begin
            maskReg <= pwdata[1:0];
         end
         statusReg <= statusNext;
         irq <= |(statusNext & (maskWr ? pwdata[1:0] : maskReg));
      end
   end

   // strength latch: changes only between transitions
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         driveSel <= 3'h0;
      end else if (hbBusy == 2'b00) begin
         driveSel <= serialCfg ? drvCode : levelDecode(driveStrengthPinMv);
      end
   end

   // sense compare and fault retry
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         senseOcp <= 1'b0;
         faultActive <= 1'b0;
         retryCnt <= {RW{1'b0}};
      end else begin
         senseOcp <= overBy(sensePositive, senseNegative, SENSE_TRIP);
         if (anyOcp) begin
            faultActive <= 1'b1;
            retryCnt <= RETRY_LOAD;
         end else if (faultActive) begin
            if (retryCnt <= 1) begin
               faultActive <= 1'b0; // retry: drive allowed again
            end
            retryCnt <= retryCnt - 1'b1;
         end
      end
   end

   // registered gate and analog-control outputs
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         highSideGate <= 2'b00;
         lowSideGate <= 2'b00;
         gatePeakActive <= 4'h0;
         gateHoldCurrent <= 4'h0;
         strongGatePulldown <= 2'b00;
         peakSourceHighMa <= 9'h000;
         peakSourceLowMa <= 9'h000;
         peakSinkHighMa <= 10'h000;
         peakSinkLowMa <= 10'h000;
         drainSourceThreshold <= {ADC_W{1'b0}};
         ampOutputEnable <= 1'b1;
         overcurrentDetect <= 1'b0;
         faultOutN <= 1'b0;
         faultOutOe <= 1'b0;
      end else begin
         highSideGate <= hbHigh;
         lowSideGate <= hbLow;
         gatePeakActive <= {hbPeak[1], hbPeak[1], hbPeak[0], hbPeak[0]};
         gateHoldCurrent <= ~{hbPeak[1], hbPeak[1], hbPeak[0], hbPeak[0]};
         strongGatePulldown <= hbStrong;
         peakSourceHighMa <= sourceMa(driveSel, 1'b1);
         peakSourceLowMa <= sourceMa(driveSel, 1'b0);
         peakSinkHighMa <= {sourceMa(driveSel, 1'b1), 1'b0};
         peakSinkLowMa <= {sourceMa(driveSel, 1'b0), 1'b0};
         drainSourceThreshold <= vdsTrip;
         ampOutputEnable <= ~(shEnable & (hbLow == 2'b11));
         overcurrentDetect <= anyOcp;
         faultOutN <= 1'b0;
         faultOutOe <= anyOcp | faultActive;
      end
   end
endmodule

// >>> rtl/hgd_consts.vh
`ifndef HGD_CONSTS_VH
`define HGD_CONSTS_VH

// clock rate in MHz
`define HGD_CLK_MHZ 100

// register byte offsets
`define HGD_OFS_CTRL 12'h000
`define HGD_OFS_STATUS 12'h004
`define HGD_OFS_MASK 12'h008
`define HGD_OFS_STATE 12'h00c

// control register fields
`define HGD_CTRL_SERIAL 0
`define HGD_CTRL_SHEN 1
`define HGD_CTRL_DEAD_LO 2
`define HGD_CTRL_DEAD_HI 3
`define HGD_CTRL_DRV_LO 4
`define HGD_CTRL_DRV_HI 6
`define HGD_CTRL_VDS_LO 7
`define HGD_CTRL_VDS_HI 9
`define HGD_CTRL_RESET 10'h000

// status / mask bits
`define HGD_ST_VDS_OCP 0
`define HGD_ST_SENSE_OCP 1
`define HGD_STATUS_RESET 2'h0
`define HGD_MASK_RESET 2'h0

// analog levels in mV
`define HGD_SENSE_OCP_MV 12'h3e8
`define HGD_VDS_MV_0 12'h03c
`define HGD_VDS_MV_1 12'h078
`define HGD_VDS_MV_2 12'h0f0
`define HGD_VDS_MV_3 12'h1e0
`define HGD_VDS_MV_4 12'h3c0
`define HGD_LVL_MV_0 350
`define HGD_LVL_MV_1 1350
`define HGD_LVL_MV_2 2500
`define HGD_LVL_MV_3 3500
`define HGD_LVL_MV_4 4500

// times in ns
`define HGD_DEAD_NS_0 120
`define HGD_DEAD_NS_1 240
`define HGD_DEAD_NS_2 480
`define HGD_DEAD_NS_3 960
`define HGD_DRIVE_NS 2000
`define HGD_IN_DEGLITCH_NS 100
`define HGD_OCP_DEGLITCH_NS 4000
`define HGD_RETRY_NS 3000000

`endif

// >>> rtl/hgd_deglitch.v
// per-bit filter: output follows input only after it held COUNT cycles
module hgd_deglitch #(
   parameter WIDTH = 4,
   parameter COUNT = 10
) (
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire [WIDTH-1:0] rawIn, // unfiltered levels
   output reg [WIDTH-1:0] cleanOut // filtered levels
);
   localparam CW = $clog2(COUNT + 1);
   localparam [CW-1:0] LIMIT = COUNT[CW-1:0];

   reg [CW-1:0] stableCnt [0:WIDTH-1]; // cycles input differs from output
   integer i;

   // restart the count on every bounce, adopt after a full hold
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cleanOut <= {WIDTH{1'b0}};
         for (i = 0; i < WIDTH; i = i + 1) begin
            stableCnt[i] <= {CW{1'b0}};
         end
      end else begin
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (rawIn[i] == cleanOut[i]) begin
               stableCnt[i] <= {CW{1'b0}}; // glitch ends, start over
            end else if (stableCnt[i] >= LIMIT - 1'b1) begin
               cleanOut[i] <= rawIn[i]; // held long enough
               stableCnt[i] <= {CW{1'b0}};
            end else begin
               stableCnt[i] <= stableCnt[i] + 1'b1;
            end
         end
      end
   end
endmodule

// >>> rtl/hgd_half_bridge.v
// one half-bridge: turn-off, handshake, dead time, peak then hold
module hgd_half_bridge #(
   parameter DRIVE_CYCLES = 200
) (
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire enable, // drive allowed, low forces both off
   input wire wantHigh, // 1 high side on, 0 low side on
   input wire highOffDet, // high-side gate seen below threshold
   input wire lowOffDet, // low-side gate seen below threshold
   input wire [7:0] deadCycles, // inserted dead time in cycles
   output reg highGate, // high-side gate commanded on
   output reg lowGate, // low-side gate commanded on
   output reg peakDrive, // peak current phase active
   output reg strongPull, // strong pulldown on low gate
   output wire busy // transition in progress
);
   localparam [4:0] S_OFF = 5'b00001;
   localparam [4:0] S_WAIT = 5'b00010;
   localparam [4:0] S_DEAD = 5'b00100;
   localparam [4:0] S_PEAK = 5'b01000;
   localparam [4:0] S_HOLD = 5'b10000;
   localparam DW = $clog2(DRIVE_CYCLES + 1);
   localparam [DW-1:0] DRIVE_LOAD = DRIVE_CYCLES[DW-1:0];

   reg [4:0] state; // one-hot sequencer state
   reg target; // side being turned on
   reg [DW-1:0] driveCnt; // remaining peak cycles
   reg [7:0] deadCnt; // remaining dead cycles

   assign busy = state[1] | state[2] | state[3];

   // sequencer
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= S_OFF;
         target <= 1'b0;
         driveCnt <= {DW{1'b0}};
         deadCnt <= 8'h00;
         highGate <= 1'b0;
         lowGate <= 1'b0;
         peakDrive <= 1'b0;
         strongPull <= 1'b0;
      end else begin
         peakDrive <= (driveCnt > 1);
         if (driveCnt != 0) begin
            driveCnt <= driveCnt - 1'b1;
         end
         if (!enable) begin
            // everything off, discharge with peak sink
            if (highGate | lowGate) begin
               driveCnt <= DRIVE_LOAD;
               peakDrive <= 1'b1;
            end
            highGate <= 1'b0;
            lowGate <= 1'b0;
            strongPull <= 1'b0;
            state <= S_OFF;
         end else begin
            case (state)
               S_OFF, S_HOLD: begin
                  strongPull <= 1'b0;
                  if (state == S_OFF || wantHigh != target) begin
                     highGate <= 1'b0; // old FET off first
                     lowGate <= 1'b0;
                     target <= wantHigh;
                     driveCnt <= DRIVE_LOAD;
                     peakDrive <= 1'b1;
                     state <= S_WAIT;
                  end
               end
               S_WAIT: begin
                  // opposite FET must be seen off before anything turns on
                  if (target ? lowOffDet : highOffDet) begin
                     deadCnt <= deadCycles;
                     state <= S_DEAD;
                  end
               end
               S_DEAD: begin
                  if (deadCnt <= 8'h01) begin
                     highGate <= target;
                     lowGate <= ~target;
                     strongPull <= target;
                     driveCnt <= DRIVE_LOAD;
                     peakDrive <= 1'b1;
                     state <= S_PEAK;
                  end else begin
                     deadCnt <= deadCnt - 1'b1;
                  end
               end
               S_PEAK: begin
                  if (driveCnt <= 1) begin
                     strongPull <= 1'b0;
                     state <= S_HOLD;
                  end
               end
               default: begin
                  state <= S_OFF;
               end
            endcase
         end
      end
   end
endmodule

// >>> dv/hgd_fet_model.sv
// external half-bridge pair: gate discharge delay and output node levels
module hgd_fet_model (
   input wire logic clock, // system clock
   input wire logic [1:0] highGate, // high gates commanded
   input wire logic [1:0] lowGate, // low gates commanded
   input wire logic [11:0] drop, // forced fet drop, mV
   input wire logic [11:0] sp, // sense node, mV
   output logic [1:0] highOff, // high gate below threshold
   output logic [1:0] lowOff, // low gate below threshold
   output logic [11:0] out1, // output 1, mV
   output logic [11:0] out2 // output 2, mV
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] hiPipe = 6'h0; // last three high commands
   logic [5:0] loPipe = 6'h0; // last three low commands
   logic [11:0] flt = 12'h0; // floating node, never steady
   // gate charge decays over three cycles
   always @(posedge clock) begin
      hiPipe <= {hiPipe[3:0], highGate};
      loPipe <= {loPipe[3:0], lowGate};
      flt <= flt + 12'h1;
   end
   // off report only once the gate has fully discharged
   assign highOff = ~(highGate | hiPipe[1:0] | hiPipe[3:2] | hiPipe[5:4]);
   assign lowOff = ~(lowGate | loPipe[1:0] | loPipe[3:2] | loPipe[5:4]);
   // conducting fet shows the forced drop, released node wanders
   assign out1 = highGate[0] ? 12'hfa0 - drop : lowGate[0] ? sp + drop : flt;
   assign out2 = highGate[1] ? 12'hfa0 - drop : lowGate[1] ? drop : flt;
endmodule

// >>> dv/hgd_asserts.sv
// port-level checks of the apb handshake, the gate sequencer and the overcurrent outputs
module hgd_asserts (
   input wire logic clock, // clock
   input wire logic rstn, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pready, // apb
   input wire logic [1:0] highSideGate, // gates
   input wire logic [1:0] lowSideGate, // gates
   input wire logic [3:0] gatePeakActive, // peak
   input wire logic [3:0] gateHoldCurrent, // hold
   input wire logic [1:0] strongGatePulldown, // pulldown
   input wire logic [8:0] peakSourceHighMa, // source
   input wire logic [8:0] peakSourceLowMa, // source
   input wire logic [9:0] peakSinkHighMa, // sink
   input wire logic [9:0] peakSinkLowMa, // sink
   input wire logic [11:0] sensePositive, // sense
   input wire logic [11:0] senseNegative, // sense
   input wire logic overcurrentDetect, // ocp
   input wire logic faultOutOe, // fault
   input wire logic ampOutputEnable // amp
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   logic [8:0] peakCnt; // length of bridge 1 peak
   logic [7:0] offCnt; // bridge 1 both-off cycles
   wire senseHigh = {1'b0, sensePositive} > {1'b0, senseNegative} + 13'h3e8;
   // helper counters
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         peakCnt <= 9'h0;
         offCnt <= 8'h0;
      end else begin
         peakCnt <= gatePeakActive[0] ? peakCnt + 9'h1 : 9'h0;
         offCnt <= (highSideGate[0] | lowSideGate[0]) ? 8'h0 : offCnt + {7'h0, ~&offCnt};
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_apb;
      s_setup |=> s_access;
   endproperty
   a_apb: assert property (p_apb) else $error("apb access not ready");
   property p_shoot;
      (highSideGate & lowSideGate) == 2'h0;
   endproperty
   a_shoot: assert property (p_shoot) else $error("both fets on");
   property p_dead;
      $rose(highSideGate[0]) || $rose(lowSideGate[0]) |-> offCnt >= 8'h0c;
   endproperty
   a_dead: assert property (p_dead) else $error("dead time short");
   property p_hold;
      $past(rstn) |-> gateHoldCurrent == ~gatePeakActive;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not inverse of peak");
   property p_peak;
      $fell(gatePeakActive[0]) && !faultOutOe |-> peakCnt >= 9'hc8;
   endproperty
   a_peak: assert property (p_peak) else $error("peak phase short");
   property p_strong;
      strongGatePulldown[0] |-> gatePeakActive[0] && !lowSideGate[0];
   endproperty
   a_strong: assert property (p_strong) else $error("pulldown outside turn-on");
   property p_sink;
      $past(rstn) |-> peakSinkHighMa == {peakSourceHighMa, 1'b0} && peakSinkLowMa == {peakSourceLowMa, 1'b0};
   endproperty
   a_sink: assert property (p_sink) else $error("sink not twice source");
   property p_fault;
      faultOutOe [*3] |-> (highSideGate | lowSideGate) == 2'h0;
   endproperty
   a_fault: assert property (p_fault) else $error("gates on in fault");
   property p_sense;
      senseHigh |-> ##[1:2] overcurrentDetect;
   endproperty
   a_sense: assert property (p_sense) else $error("sense overcurrent missed");
   property p_amp;
      !ampOutputEnable |-> lowSideGate == 2'h3;
   endproperty
   a_amp: assert property (p_amp) else $error("amp off outside brake");
endmodule
bind hgd_top hgd_asserts i_chk (.clock, .rstn, .psel, .penable, .pready, .highSideGate, .lowSideGate,
   .gatePeakActive, .gateHoldCurrent, .strongGatePulldown, .peakSourceHighMa, .peakSourceLowMa,
   .peakSinkHighMa, .peakSinkLowMa, .sensePositive, .senseNegative, .overcurrentDetect, .faultOutOe,
   .ampOutputEnable);

// >>> dv/hgd_top_tb.sv
// bench: apb tasks, gate transitions, overcurrent paths
module hgd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h0, sensePositive = 12'h0, senseNegative = 12'h0, drop = 12'h0;
   logic [11:0] drainSupplySense = 12'hfa0, lowSideSourceTwo = 12'h0, driveStrengthPinMv = 12'h0;
   logic [11:0] vdsPinMv = 12'h0, halfBridgeOutputOne, halfBridgeOutputTwo, drainSourceThreshold;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, ampOutputEnable, overcurrentDetect, faultOutN, faultOutOe;
   logic [1:0] bridgeWantHigh = 2'h0, bridgeEnable = 2'h0, highOffDet, lowOffDet;
   logic [1:0] highSideGate, lowSideGate, strongGatePulldown;
   logic [3:0] gatePeakActive, gateHoldCurrent;
   logic [8:0] peakSourceHighMa, peakSourceLowMa;
   logic [9:0] peakSinkHighMa, peakSinkLowMa;
   int n_errors = 0, check_count = 0;
   always #5 clock = ~clock;
   hgd_top #(.RETRY_CYCLES(50)) i_dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .bridgeWantHigh, .bridgeEnable, .highOffDet, .lowOffDet, .sensePositive,
      .senseNegative, .drainSupplySense, .halfBridgeOutputOne, .halfBridgeOutputTwo, .lowSideSourceTwo,
      .driveStrengthPinMv, .vdsPinMv, .highSideGate, .lowSideGate, .gatePeakActive, .gateHoldCurrent,
      .strongGatePulldown, .peakSourceHighMa, .peakSourceLowMa, .peakSinkHighMa, .peakSinkLowMa,
      .drainSourceThreshold, .ampOutputEnable, .overcurrentDetect, .faultOutN, .faultOutOe);
   hgd_fet_model i_fet (.clock, .highGate(highSideGate), .lowGate(lowSideGate), .drop, .sp(sensePositive),
      .highOff(highOffDet), .lowOff(lowOffDet), .out1(halfBridgeOutputOne), .out2(halfBridgeOutputTwo));
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // move bridge 1, count both-off cycles until the target gate is on
   task automatic flip(input logic v, output int gap);
      int n;
      n = 0;
      gap = 0;
      bridgeWantHigh[0] <= v;
      do begin
         @(negedge clock);
         n++;
         if ((highSideGate[0] | lowSideGate[0]) === 1'b0) gap++;
      end while ((v ? highSideGate[0] : lowSideGate[0]) !== 1'b1 && n < 2000);
      cyc(220);
   endtask
   task automatic results();
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #200us;
      n_errors++;
      results();
   end
   initial begin
      int g[4];
      int gp;
      int gx;
      cyc(16);
      rstn <= 1'b1;
      cyc(1);
      for (int a = 0; a < 16; a += 4) begin
         apb(1'b0, 12'(a), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(32'(peakSourceHighMa), 32'ha);
      chk(32'(peakSinkLowMa), 32'h14);
      chk(32'(drainSourceThreshold), 32'h3c);
      driveStrengthPinMv <= 12'hbb8;
      cyc(5);
      chk(32'(peakSourceHighMa), 32'h9b);
      chk(32'(peakSourceLowMa), 32'h82);
      chk(32'(peakSinkHighMa), 32'h136);
      bridgeEnable <= 2'h3;
      cyc(300);
      bridgeWantHigh <= 2'h1;
      cyc(3);
      bridgeWantHigh <= 2'h0;
      cyc(30);
      chk(32'({highSideGate, lowSideGate}), 32'h3);
      flip(1'b1, gp);
      flip(1'b0, gx);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 12'h0, 32'h31 | (k << 2));
         flip(1'b1, g[k]);
         flip(1'b0, gx);
         chk(32'(g[k] - g[0]), 32'((12 << k) - 12));
      end
      chk(32'(gp), 32'(g[1]));
      chk(32'(peakSourceHighMa), 32'h9b);
      apb(1'b1, 12'h0, 32'h33);
      cyc(3);
      chk({31'h0, ampOutputEnable}, 32'h0);
      apb(1'b1, 12'h0, 32'h31);
      cyc(3);
      chk({31'h0, ampOutputEnable}, 32'h1);
      apb(1'b1, 12'h8, 32'h2);
      sensePositive <= 12'h5dc;
      cyc(5);
      chk({29'h0, faultOutN, faultOutOe, irq}, 32'h3);
      chk(32'({highSideGate, lowSideGate}), 32'h0);
      sensePositive <= 12'h0;
      cyc(60);
      apb(1'b0, 12'h4, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 12'h8, 32'h0);
      cyc(3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h4, 32'h2);
      apb(1'b0, 12'h4, 32'h0);
      chk(rd, 32'h0);
      cyc(400);
      drop <= 12'h64;
      cyc(300);
      apb(1'b0, 12'h4, 32'h0);
      chk(rd, 32'h0);
      cyc(150);
      apb(1'b0, 12'h4, 32'h0);
      chk(rd & 32'h1, 32'h1);
      drop <= 12'h0;
      results();
   end
endmodule
